// ---- spm_port.sv ----
// How it works
// RULE_01 - slave: external SCK, MOSI in, MISO out
// RULE_02 - slave write fills buffer, loads if idle
// RULE_03 - busy shifter takes new byte after completion
// RULE_04 - slave byte waits in buffer while deselected
// RULE_05 - full flag until moved; write overwrites
// RULE_06 - deselect mid-byte aborts, no flag
// RULE_07 - every select reloads buffer into shifter
// RULE_08 - slave shifting continues during suspend
// RULE_09 - completion sets flag bit 7 and interrupt
// RULE_10 - role field: off, master, slave, reserved
// RULE_11 - bit 3 sets clock idle level
// RULE_12 - firmware matches phase and level to master
// RULE_13 - rate field sets master clock rate
// RULE_14 - role off holds all bypasses at one
// RULE_15 - outputs get live bypass, inputs one
// RULE_16 - firmware sets port data and drive modes
// RULE_17 - master select by firmware; slave SS input
// RULE_18 - master write starts 8-bit MSB-first exchange
// RULE_19 - firmware reads byte before next completes
// RULE_20 - master duty 33% fastest, else 50%
// RULE_21 - data register: write tx, read rx
// RULE_22 - phase bit picks sample and change edges
// RULE_23 - slave eighth bit moves byte to rx buffer
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`include "spm_defines.svh"
module spm_port
   import spm_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   spm_if.dev              link,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr_stb,
   input  wire logic       rd_stb,
   output logic      [7:0] rdata_r,
   output logic            irq_r,
   input  wire logic [2:0] gpio_data,
   input  wire logic [2:0] gpio_oe_n,
   output logic      [2:0] byp_r
);
   // ****************
   // helpers
   // ****************
   function automatic logic [10:0] seg_len(input logic [1:0] rate,
                                           input logic       act);
      logic [31:0] per;
      logic [31:0] len;
      case (rate)
         2'b00:   per = `SPM_CLK_HZ / `SPM_RATE_0;
         2'b01:   per = `SPM_CLK_HZ / `SPM_RATE_1;
         2'b10:   per = `SPM_CLK_HZ / `SPM_RATE_2;
         default: per = `SPM_CLK_HZ / `SPM_RATE_3;
      endcase
      // fastest rate keeps the clock active one third of the bit
      if (rate == 2'b00)
         len = act ? per / 3 : per - per / 3;
      else
         len = per / 2;
      seg_len = 11'(len - 1);
   endfunction

   // ****************
   // state
   // ****************
   logic [5:0]  ctrl_r;
   logic        cmpl_r;
   logic        txf_r;
   logic [7:0]  txbuf_r;
   logic [7:0]  rxbuf_r;
   logic [7:0]  sh_r;
   logic [7:0]  rxsh_r;
   logic [3:0]  cnt_r;
   logic        busy_r;
   spm_mst_e    mst_r;
   logic [10:0] tick_r;
   logic        sck_d_r;
   logic        ss_d_r;
   logic [2:0]  pin_o_r;
   logic [2:0]  oe_n_r;
   logic [3:0]  pin_q;

   spm_sync #(.W(4), .RST_VAL(4'hF)) u_sync (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .d       ({link.ss_n, link.sck, link.miso, link.mosi}),
      .q       (pin_q)
   );

   // ****************
   // decode
   // ****************
   spm_role_e   role;
   logic        is_m;
   logic        is_s;
   logic        idle_lvl;
   logic        samp_ph;
   logic [1:0]  rate;
   logic        ss_q;
   logic        sck_q;
   logic        ss_lo;
   logic        ss_fall;
   logic        ss_rise;
   logic        s_lead;
   logic        s_trail;
   logic        m_lead;
   logic        m_trail;
   logic        lead;
   logic        trail;
   logic        samp;
   logic        chg;
   logic        din;
   logic [7:0]  rx_cat;
   logic [7:0]  rx_fin;
   logic        done;
   logic        abort;
   logic        wr_data;
   logic        wr_ctrl;
   logic        load;

   assign role    = spm_role_e'(ctrl_r[`SPM_F_MODE_HI:`SPM_F_MODE_LO]);
   assign is_m    = (role == ROLE_MASTER);                 // [RULE_10]
   assign is_s    = (role == ROLE_SLAVE);                  // [RULE_10]
   assign idle_lvl = ctrl_r[`SPM_BIT_IDLE];
   assign samp_ph  = ctrl_r[`SPM_BIT_PHASE];
   assign rate    = ctrl_r[`SPM_F_RATE_HI:`SPM_F_RATE_LO];
   assign ss_q    = pin_q[3];
   assign sck_q   = pin_q[2];
   assign ss_lo   = is_s & ~ss_q;                          // [RULE_17]
   assign ss_fall = ss_lo & ss_d_r;
   assign ss_rise = is_s & ss_q & ~ss_d_r;
   // edges of the incoming clock are only seen while selected
   assign s_lead  = ss_lo & (sck_q != idle_lvl)
                  & (sck_d_r == idle_lvl);                 // [RULE_01]
   assign s_trail = ss_lo & (sck_q == idle_lvl)
                  & (sck_d_r != idle_lvl);                 // [RULE_01]
   assign m_lead  = (mst_r == M_SETUP) & (tick_r == 11'h000);
   assign m_trail = (mst_r == M_ACT) & (tick_r == 11'h000);
   assign lead    = is_m ? m_lead : s_lead;
   assign trail   = is_m ? m_trail : s_trail;
   assign samp    = busy_r & (samp_ph ? trail : lead);     // [RULE_22]
   assign chg     = busy_r & (samp_ph ? lead : trail);     // [RULE_22]
   assign din     = is_m ? pin_q[`SPM_PIN_MISO] : pin_q[`SPM_PIN_MOSI];
   assign rx_cat  = {rxsh_r[6:0], din};
   assign rx_fin  = samp ? rx_cat : rxsh_r;
   // no suspend input gates this: the shifter runs on regardless
   assign done    = busy_r & (is_m                         // [RULE_08]
                    ? m_trail & (samp_ph ? cnt_r == 4'h7 : cnt_r == 4'h8)
                    : samp & (cnt_r == 4'h7));             // [RULE_23]
   assign abort   = busy_r & ss_rise;                      // [RULE_06]
   assign wr_data = wr_stb & (addr == `SPM_ADDR_DATA);     // [RULE_21]
   assign wr_ctrl = wr_stb & (addr == `SPM_ADDR_CTRL);
   // select edge reloads even an already sent byte
   assign load    = ss_fall                                // [RULE_07]
                  | (~busy_r & txf_r & (is_m | ss_lo));    // [RULE_02] [RULE_03] [RULE_04]

   // ****************
   // next values
   // ****************
   logic        busy_nxt;
   logic        txf_nxt;
   logic        cmpl_nxt;
   logic [7:0]  sh_nxt;
   logic [3:0]  cnt_nxt;
   spm_mst_e    mst_nxt;
   logic [10:0] tick_nxt;
   logic        sck_nxt;
   logic [2:0]  byp_nxt;
   logic [7:0]  rd_nxt;

   assign busy_nxt = !(is_m | is_s) ? 1'b0 :
                     load ? 1'b1 :
                     (done | abort) ? 1'b0 : busy_r;
   // a fresh write wins over the move into the shifter
   assign txf_nxt  = wr_data ? 1'b1 : load ? 1'b0 : txf_r; // [RULE_05]
   // hardware set wins over a clearing write
   assign cmpl_nxt = done | (wr_ctrl ? cmpl_r & wdata[`SPM_BIT_DONE]
                                     : cmpl_r);            // [RULE_09]
   assign sh_nxt   = load ? txbuf_r :
                     done ? rx_fin :                       // [RULE_18]
                     (chg & (cnt_r != 4'h0)) ? {sh_r[6:0], 1'b0} : sh_r;
   assign cnt_nxt  = (load | done | abort) ? 4'h0 :
                     samp ? cnt_r + 4'h1 : cnt_r;

   always_comb begin
      mst_nxt  = mst_r;
      tick_nxt = tick_r;
      case (mst_r)
         M_IDLE: begin
            if (is_m & load) begin                         // [RULE_18]
               mst_nxt  = M_SETUP;
               tick_nxt = seg_len(rate, 1'b0);             // [RULE_13]
            end
         end
         M_SETUP: begin
            if (tick_r == 11'h000) begin
               mst_nxt  = M_ACT;
               tick_nxt = seg_len(rate, 1'b1);             // [RULE_20]
            end else begin
               tick_nxt = tick_r - 11'h001;
            end
         end
         M_ACT: begin
            if (tick_r != 11'h000) begin
               tick_nxt = tick_r - 11'h001;
            end else if (done) begin
               mst_nxt  = M_IDLE;
            end else begin
               mst_nxt  = M_SETUP;
               tick_nxt = seg_len(rate, 1'b0);             // [RULE_13]
            end
         end
         default: mst_nxt = M_IDLE;
      endcase
      if (!is_m)
         mst_nxt = M_IDLE;
   end

   assign sck_nxt = (mst_nxt == M_ACT) ? ~idle_lvl : idle_lvl; // [RULE_11]
   // pins that act as inputs keep their bypass at one
   assign byp_nxt[`SPM_PIN_SCK]  = is_m ? sck_nxt : 1'b1;  // [RULE_14] [RULE_15]
   assign byp_nxt[`SPM_PIN_MOSI] = is_m ? sh_nxt[7] : 1'b1; // [RULE_15]
   assign byp_nxt[`SPM_PIN_MISO] = is_s ? sh_nxt[7] : 1'b1; // [RULE_01] [RULE_15]

   always_comb begin
      if (!rd_stb)
         rd_nxt = 8'h00;
      else if (addr == `SPM_ADDR_DATA)
         rd_nxt = rxbuf_r;                                 // [RULE_21]
      else if (addr == `SPM_ADDR_CTRL)
         rd_nxt = {cmpl_r, txf_r, ctrl_r};
      else
         rd_nxt = 8'h00;
   end

   // ****************
   // registers
   // ****************
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ctrl_r  <= `SPM_CTRL_RST;
         cmpl_r  <= 1'b0;
         txf_r   <= 1'b0;
         txbuf_r <= `SPM_DATA_RST;
         rxbuf_r <= `SPM_DATA_RST;
         rdata_r <= 8'h00;
         irq_r   <= 1'b0;
      end else begin
         if (wr_ctrl)
            ctrl_r <= wdata[5:0];
         if (wr_data)
            txbuf_r <= wdata;                              // [RULE_05]
         if (done)
            rxbuf_r <= rx_fin;                             // [RULE_23]
         cmpl_r  <= cmpl_nxt;
         txf_r   <= txf_nxt;
         rdata_r <= rd_nxt;
         irq_r   <= done;                                  // [RULE_09]
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         sh_r    <= 8'h00;
         rxsh_r  <= 8'h00;
         cnt_r   <= 4'h0;
         busy_r  <= 1'b0;
         mst_r   <= M_IDLE;
         tick_r  <= 11'h000;
         sck_d_r <= 1'b1;
         ss_d_r  <= 1'b1;
      end else begin
         sh_r    <= sh_nxt;
         cnt_r   <= cnt_nxt;
         busy_r  <= busy_nxt;
         mst_r   <= mst_nxt;
         tick_r  <= tick_nxt;
         sck_d_r <= sck_q;
         ss_d_r  <= ss_q;
         if (samp)
            rxsh_r <= rx_cat;                              // [RULE_22]
      end
   end

   // port data bits gate the pins; drive modes stay firmware's own
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         byp_r   <= 3'h7;
         pin_o_r <= 3'h7;
         oe_n_r  <= 3'h7;
      end else begin
         byp_r   <= byp_nxt;
         pin_o_r <= byp_nxt & gpio_data;                   // [RULE_16]
         oe_n_r  <= gpio_oe_n;                             // [RULE_16]
      end
   end

   assign link.sck_dev_o     = pin_o_r[`SPM_PIN_SCK];
   assign link.sck_dev_oe_n  = oe_n_r[`SPM_PIN_SCK];
   assign link.mosi_dev_o    = pin_o_r[`SPM_PIN_MOSI];
   assign link.mosi_dev_oe_n = oe_n_r[`SPM_PIN_MOSI];
   assign link.miso_dev_o    = pin_o_r[`SPM_PIN_MISO];
   assign link.miso_dev_oe_n = oe_n_r[`SPM_PIN_MISO];
endmodule // spm_port

// ---- spm_defines.svh ----
`ifndef SPM_DEFINES_SVH
`define SPM_DEFINES_SVH
// ****************
// register map
// ****************
`define SPM_ADDR_DATA  8'h60
`define SPM_ADDR_CTRL  8'h61
`define SPM_CTRL_RST   6'h00
`define SPM_DATA_RST   8'h00
`define SPM_BIT_DONE   7
`define SPM_BIT_TXF    6
`define SPM_F_MODE_HI  5
`define SPM_F_MODE_LO  4
`define SPM_BIT_IDLE   3
`define SPM_BIT_PHASE  2
`define SPM_F_RATE_HI  1
`define SPM_F_RATE_LO  0
// ****************
// pin order in the three-pin vectors
// ****************
`define SPM_PIN_SCK    2
`define SPM_PIN_MISO   1
`define SPM_PIN_MOSI   0
// ****************
// timing
// ****************
`define SPM_CLK_HZ     100000000
`define SPM_RATE_0     2000000
`define SPM_RATE_1     1000000
`define SPM_RATE_2     500000
`define SPM_RATE_3     62500
`define SPM_PEER_HALF  8
`endif

// ---- spm_pkg.sv ----
package spm_pkg;
   typedef enum logic [1:0] {
      ROLE_OFF    = 2'b00,
      ROLE_MASTER = 2'b01,
      ROLE_SLAVE  = 2'b10,
      ROLE_RSVD   = 2'b11
   } spm_role_e;

   typedef enum logic [1:0] {
      M_IDLE  = 2'b00,
      M_SETUP = 2'b01,
      M_ACT   = 2'b10
   } spm_mst_e;
endpackage

// ---- spm_if.sv ----
`timescale 1ns/1ps
interface spm_if;
   logic sck_dev_o;
   logic sck_dev_oe_n;
   logic mosi_dev_o;
   logic mosi_dev_oe_n;
   logic miso_dev_o;
   logic miso_dev_oe_n;
   logic sck_peer_o;
   logic sck_peer_oe_n;
   logic mosi_peer_o;
   logic mosi_peer_oe_n;
   logic miso_peer_o;
   logic miso_peer_oe_n;
   logic ss_n_peer_o;
   logic ss_n_peer_oe_n;
   logic sck;
   logic mosi;
   logic miso;
   logic ss_n;

   // undriven wires float high through the pull-ups
   assign sck  = !sck_dev_oe_n ? sck_dev_o :
                 !sck_peer_oe_n ? sck_peer_o : 1'b1;
   assign mosi = !mosi_dev_oe_n ? mosi_dev_o :
                 !mosi_peer_oe_n ? mosi_peer_o : 1'b1;
   assign miso = !miso_dev_oe_n ? miso_dev_o :
                 !miso_peer_oe_n ? miso_peer_o : 1'b1;
   assign ss_n = !ss_n_peer_oe_n ? ss_n_peer_o : 1'b1;

   modport dev (input sck, mosi, miso, ss_n,
                output sck_dev_o, sck_dev_oe_n, mosi_dev_o,
                mosi_dev_oe_n, miso_dev_o, miso_dev_oe_n);
   modport peer (input sck, mosi, miso, ss_n,
                 output sck_peer_o, sck_peer_oe_n, mosi_peer_o,
                 mosi_peer_oe_n, miso_peer_o, miso_peer_oe_n,
                 ss_n_peer_o, ss_n_peer_oe_n);
endinterface // spm_if

// ---- spm_sync.sv ----
`timescale 1ns/1ps
module spm_sync #(
   parameter int             W       = 1,
   parameter logic [W-1:0]   RST_VAL = '0
) (
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         meta_r <= RST_VAL;
         q      <= RST_VAL;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule // spm_sync

// ---- spm_peer.sv ----
`timescale 1ns/1ps
`include "spm_defines.svh"
module spm_peer
   import spm_pkg::*;
#(
   parameter int HALF = `SPM_PEER_HALF
) (
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   spm_if.peer             link,
   input  wire logic       is_master,
   input  wire logic       idle_lvl,
   input  wire logic       samp_ph,
   input  wire logic       sel,
   input  wire logic       start,
   input  wire logic [7:0] tx_byte,
   output logic      [7:0] rx_byte_r,
   output logic            done_r,
   output logic            busy_r
);
   logic [2:0] pin_q;
   logic [7:0] sh_r;
   logic [7:0] rxsh_r;
   logic [3:0] cnt_r;
   logic [7:0] half_r;
   logic [4:0] edge_r;
   logic       sck_r;
   logic       ss_n_r;
   logic       sck_d_r;
   logic       sel_d_r;
   logic       m_oe_n_r;
   logic       s_oe_n_r;

   spm_sync #(.W(3), .RST_VAL(3'h7)) u_sync (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .d       ({link.sck, link.miso, link.mosi}),
      .q       (pin_q)
   );

   logic       sck_q;
   logic       tick;
   logic       m_lead;
   logic       m_trail;
   logic       s_lead;
   logic       s_trail;
   logic       xfer;
   logic       samp;
   logic       chg;
   logic       din;
   logic [7:0] rx_cat;
   logic       done;
   logic       m_go;
   logic       load;

   assign sck_q   = pin_q[2];
   assign tick    = busy_r & (half_r == 8'h00);
   assign m_lead  = tick & (edge_r < 5'd16) & ~edge_r[0];
   assign m_trail = tick & (edge_r < 5'd16) & edge_r[0];
   // phase and level are set to match the device's own
   assign s_lead  = sel & (sck_q != idle_lvl)
                  & (sck_d_r == idle_lvl);                 // [RULE_12]
   assign s_trail = sel & (sck_q == idle_lvl) & (sck_d_r != idle_lvl);
   assign xfer    = is_master ? busy_r : sel;
   assign samp    = xfer & (samp_ph ? (is_master ? m_trail : s_trail)
                                    : (is_master ? m_lead : s_lead));
   assign chg     = xfer & (samp_ph ? (is_master ? m_lead : s_lead)
                                    : (is_master ? m_trail : s_trail));
   assign din     = is_master ? pin_q[1] : pin_q[0];
   assign rx_cat  = {rxsh_r[6:0], din};
   assign done    = samp & (cnt_r == 4'h7);
   assign m_go    = is_master & start & ~busy_r;
   assign load    = m_go | (~is_master & sel & ~sel_d_r);

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         sh_r      <= 8'h00;
         rxsh_r    <= 8'h00;
         cnt_r     <= 4'h0;
         rx_byte_r <= 8'h00;
         done_r    <= 1'b0;
         sck_d_r   <= 1'b1;
         sel_d_r   <= 1'b0;
      end else begin
         sck_d_r <= sck_q;
         sel_d_r <= sel;
         done_r  <= done;
         if (load) begin
            sh_r  <= tx_byte;
            cnt_r <= 4'h0;
         end else if (samp) begin
            rxsh_r <= rx_cat;
            cnt_r  <= done ? 4'h0 : cnt_r + 4'h1;
         end
         if (chg & (cnt_r != 4'h0) & ~load)
            sh_r <= {sh_r[6:0], 1'b0};
         if (done)
            rx_byte_r <= rx_cat;
      end
   end

   // select is held through a lead-in of two half periods
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         busy_r   <= 1'b0;
         half_r   <= 8'h00;
         edge_r   <= 5'd0;
         sck_r    <= 1'b0;
         ss_n_r   <= 1'b1;
         m_oe_n_r <= 1'b1;
         s_oe_n_r <= 1'b1;
      end else begin
         m_oe_n_r <= ~is_master;
         s_oe_n_r <= ~(~is_master & sel);
         if (!busy_r)
            sck_r <= idle_lvl;
         if (m_go) begin
            busy_r <= 1'b1;
            ss_n_r <= 1'b0;
            edge_r <= 5'd0;
            half_r <= 8'(2 * HALF - 1);
         end else if (busy_r & ~tick) begin
            half_r <= half_r - 8'h01;
         end else if (tick & (edge_r < 5'd16)) begin
            sck_r  <= ~sck_r;
            edge_r <= edge_r + 5'd1;
            half_r <= 8'(HALF - 1);
         end else if (tick) begin
            busy_r <= 1'b0;
            ss_n_r <= 1'b1;
         end
      end
   end

   assign link.sck_peer_o     = sck_r;
   assign link.sck_peer_oe_n  = m_oe_n_r;
   assign link.mosi_peer_o    = sh_r[7];
   assign link.mosi_peer_oe_n = m_oe_n_r;
   assign link.ss_n_peer_o    = ss_n_r;
   assign link.ss_n_peer_oe_n = m_oe_n_r;
   assign link.miso_peer_o    = sh_r[7];
   assign link.miso_peer_oe_n = s_oe_n_r;
endmodule // spm_peer

// ---- spm_chk_sva.sv ----
`timescale 1ns/1ps
module spm_chk_sva (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic sck,
   input wire logic miso,
   input wire logic ss_n,
   input wire logic sck_dev_oe_n,
   input wire logic mosi_dev_oe_n,
   input wire logic miso_dev_oe_n,
   input wire logic sck_peer_oe_n,
   input wire logic miso_peer_oe_n
);
   // ****************
   // helper counters
   // ****************
   logic       sck_q_r;
   logic       idle_r;
   logic [4:0] edges_r;
   logic [3:0] gap_r;
   wire        sck_edge = sck != sck_q_r;

   always_ff @(posedge clk_sys) begin
      sck_q_r <= sck;
      if (ss_n)
         idle_r <= sck;
      if (!rst_n || ss_n)
         edges_r <= 5'h00;
      else if (sck_edge)
         edges_r <= edges_r + 5'h01;
      if (!rst_n)
         gap_r <= 4'hF;
      else if (sck_edge)
         gap_r <= 4'h0;
      else if (gap_r != 4'hF)
         gap_r <= gap_r + 4'h1;
   end

   // ****************
   // properties
   // ****************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   sel_lead_a: assert property ($fell(ss_n) |-> $stable(sck)[*8])
      else $error("clock moved too soon after select");
   edge_count_a: assert property (edges_r <= 5'h10)
      else $error("more than sixteen clock edges in one frame");
   idle_level_a: assert property ($rose(ss_n) |-> sck == idle_r)
      else $error("clock not back at idle level at deselect");
   sck_owner_a: assert property (sck_dev_oe_n || sck_peer_oe_n)
      else $error("both ends drive the clock");
   miso_owner_a: assert property (miso_dev_oe_n || miso_peer_oe_n)
      else $error("both ends drive the slave data line");
   edge_gap_a: assert property ($changed(sck) |-> gap_r >= 4'h4)
      else $error("clock edges too close together");
   miso_hold_a: assert property (!ss_n && $changed(sck) |-> $stable(miso))
      else $error("slave data changed on a clock edge");
   reset_quiet_a: assert property ($rose(rst_n) |->
      sck_dev_oe_n && mosi_dev_oe_n && miso_dev_oe_n && ss_n)
      else $error("pins driven right after reset");
endmodule // spm_chk_sva

// ---- tb_top.sv ----
`timescale 1ns/1ps
`include "spm_defines.svh"
module tb_top;
   // ****************
   // stimulus and design
   // ****************
   logic       clk_sys   = 1'b0;
   logic       rst_n     = 1'b0;
   logic       abort     = 1'b0;
   logic [7:0] addr      = 8'h00;
   logic [7:0] wdata     = 8'h00;
   logic       wr_stb    = 1'b0;
   logic       rd_stb    = 1'b0;
   logic [2:0] gpio_data = 3'h7;
   logic [2:0] gpio_oe_n = 3'h7;
   logic       is_master = 1'b0;
   logic       idle_lvl  = 1'b0;
   logic       samp_ph   = 1'b0;
   logic       sel       = 1'b0;
   logic       start     = 1'b0;
   logic [7:0] tx_byte   = 8'h00;
   logic [7:0] rdata_r;
   logic [7:0] rx_byte_r;
   logic [2:0] byp_r;
   logic       irq_r;
   logic [7:0] d;
   int         n_mismatch = 0;
   int         num_checks = 0;
   int         n_irq      = 0;
   int         cyc        = 0;
   int         ehi [4]    = '{16, 50, 100, 800};
   int         elo [4]    = '{34, 50, 100, 800};
   wire        peer_rst_n = rst_n & ~abort;

   always #5 clk_sys = ~clk_sys;

   spm_if lnk ();
   spm_port u_spm_port (.clk_sys(clk_sys), .rst_n(rst_n), .link(lnk),
      .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
      .rdata_r(rdata_r), .irq_r(irq_r), .gpio_data(gpio_data),
      .gpio_oe_n(gpio_oe_n), .byp_r(byp_r));
   spm_peer u_spm_peer (.clk_sys(clk_sys), .rst_n(peer_rst_n), .link(lnk),
      .is_master(is_master), .idle_lvl(idle_lvl), .samp_ph(samp_ph),
      .sel(sel), .start(start), .tx_byte(tx_byte), .rx_byte_r(rx_byte_r),
      .done_r(), .busy_r());
   spm_chk_sva u_spm_chk_sva (.clk_sys(clk_sys), .rst_n(rst_n),
      .sck(lnk.sck), .miso(lnk.miso), .ss_n(lnk.ss_n),
      .sck_dev_oe_n(lnk.sck_dev_oe_n), .mosi_dev_oe_n(lnk.mosi_dev_oe_n),
      .miso_dev_oe_n(lnk.miso_dev_oe_n),
      .sck_peer_oe_n(lnk.sck_peer_oe_n),
      .miso_peer_oe_n(lnk.miso_peer_oe_n));

   // slowest rate alone takes about 13k cycles
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (irq_r === 1'b1)
         n_irq <= n_irq + 1;
      if (cyc == 40000) begin
         n_mismatch = n_mismatch + 1;
         conclude();
      end
   end

   // ****************
   // shared tasks
   // ****************
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      addr <= a;
      wdata <= v;
      wr_stb <= 1'b1;
      @(posedge clk_sys);
      wr_stb <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk_sys);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk_sys);
      rd_stb <= 1'b0;
      #1 v = rdata_r;
   endtask

   task automatic wait_irq(input int t);
      int k;
      k = 0;
      while (n_irq < t && k < 20000) begin
         @(posedge clk_sys);
         #1 k++;
      end
      chk(n_irq, t);
   endtask

   // pins released first so the two ends never fight over a wire
   task automatic cfg(input logic m, input logic [7:0] c, input logic [2:0] oe);
      gpio_oe_n <= 3'h7;
      tick(6);
      is_master <= m;
      idle_lvl <= c[3];
      samp_ph <= c[2];
      wr(`SPM_ADDR_CTRL, c);
      tick(6);
      gpio_oe_n <= oe;
      tick(4);
   endtask

   task automatic pulse_start(input logic [7:0] b);
      tx_byte <= b;
      start <= 1'b1;
      @(posedge clk_sys);
      start <= 1'b0;
   endtask

   // ****************
   // scenarios
   // ****************
   task automatic t_regs();
      chk(byp_r, 3'h7);
      rd(`SPM_ADDR_CTRL, d);
      chk(d, 8'h00);
      rd(`SPM_ADDR_DATA, d);
      chk(d, 8'h00);
      rd(8'h62, d);
      chk(d, 8'h00);
      wr(`SPM_ADDR_CTRL, 8'h7F);
      wr(8'h62, 8'h00);
      rd(`SPM_ADDR_CTRL, d);
      chk(d, 8'h3F);
      chk(byp_r, 3'h7);
   endtask

   task automatic t_master();
      int hi;
      int lo;
      cfg(1'b0, 8'h10, 3'h2);
      chk(byp_r[1], 1'b1);
      for (int i = 0; i < 4; i++) begin
         wr(`SPM_ADDR_CTRL, 8'h10 | i[7:0]);
         tx_byte <= 8'hC0 + i[7:0];
         sel <= 1'b1;
         wr(`SPM_ADDR_DATA, 8'h35 + i[7:0]);
         hi = 0;
         lo = 0;
         while (lnk.sck !== 1'b1)
            @(posedge clk_sys);
         while (lnk.sck === 1'b1) begin
            @(posedge clk_sys);
            hi++;
         end
         while (lnk.sck === 1'b0) begin
            @(posedge clk_sys);
            lo++;
         end
         chk(hi, ehi[i]);
         chk(lo, elo[i]);
         wait_irq(i + 1);
         tick(10);
         chk(rx_byte_r, 8'h35 + i[7:0]);
         rd(`SPM_ADDR_DATA, d);
         chk(d, 8'hC0 + i[7:0]);
         rd(`SPM_ADDR_CTRL, d);
         chk(d, 8'h90 | i[7:0]);
         sel <= 1'b0;
      end
      // second and third byte land while the first is shifting
      cfg(1'b0, 8'h1C, 3'h2);
      tx_byte <= 8'h66;
      sel <= 1'b1;
      wr(`SPM_ADDR_DATA, 8'h11);
      wr(`SPM_ADDR_DATA, 8'h22);
      wr(`SPM_ADDR_DATA, 8'h44);
      rd(`SPM_ADDR_CTRL, d);
      chk(d, 8'h5C);
      wait_irq(5);
      rd(`SPM_ADDR_CTRL, d);
      chk(d, 8'h9C);
      wait_irq(6);
      tick(10);
      chk(rx_byte_r, 8'h44);
      chk(lnk.sck, 1'b1);
      sel <= 1'b0;
   endtask

   task automatic t_slave();
      cfg(1'b1, 8'h20, 3'h5);
      chk(byp_r & 3'h5, 3'h5);
      wr(`SPM_ADDR_DATA, 8'h96);
      tick(40);
      rd(`SPM_ADDR_CTRL, d);
      chk(d, 8'h60);
      for (int k = 0; k < 2; k++) begin
         pulse_start(8'h5A + k[7:0]);
         wait_irq(7 + k);
         rd(`SPM_ADDR_DATA, d);
         chk(d, 8'h5A + k[7:0]);
         tick(30);
         chk(rx_byte_r, 8'h96);
         rd(`SPM_ADDR_CTRL, d);
         chk(d, 8'hA0);
      end
      // deselect mid-byte while the clock sits at its idle level
      cfg(1'b1, 8'h28, 3'h5);
      pulse_start(8'h81);
      tick(36);
      while (lnk.sck !== 1'b1)
         @(posedge clk_sys);
      tick(2);
      abort <= 1'b1;
      tick(4);
      abort <= 1'b0;
      tick(200);
      chk(n_irq, 8);
      rd(`SPM_ADDR_CTRL, d);
      chk(d, 8'h28);
      cfg(1'b1, 8'h00, 3'h7);
      chk(byp_r, 3'h7);
   endtask

   initial begin
      tick(8);
      rst_n <= 1'b1;
      tick(2);
      t_regs();
      t_master();
      t_slave();
      conclude();
   end
endmodule // tb_top
